// *** analyzer_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module analyzer_model (
  // Clock
  input wire logic core_clk,
  // Timing fields of the frame descriptor
  output logic inValid,
  output logic [2:0] rewriteOpCode,
  output logic addSubMode,
  output logic egressDelayReq,
  output logic ingressBackplane,
  output logic [47:0] rxStamp,
  output logic [47:0] txStamp
);
  initial
  begin
    {inValid, rewriteOpCode, addSubMode, egressDelayReq, ingressBackplane} = 7'h00;
    {rxStamp, txStamp} = 96'h0;
  end

  // One-cycle descriptor pulse; the timing fields travel with it
  task automatic send(input logic [2:0] op, input logic asm, input logic dly, input logic ibp,
    input logic [47:0] rx, input logic [47:0] tx);
    @(posedge core_clk);
    inValid <= 1'h1;
    rewriteOpCode <= op;
    addSubMode <= asm;
    egressDelayReq <= dly;
    ingressBackplane <= ibp;
    rxStamp <= rx;
    txStamp <= tx;
    @(posedge core_clk);
    inValid <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** egress_frame_rewriter.sv ***
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module egress_frame_rewriter
  import egress_rewriter_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame descriptor from analyzer
  input wire logic inValid,
  input wire logic [2:0] classPcp,
  input wire logic classDei,
  input wire logic [11:0] classVid,
  input wire logic classCtag,
  input wire logic [2:0] qosClass,
  input wire logic dropLevel,
  input wire logic [2:0] tagPushMask,
  input wire logic tagsPopped,
  input wire logic [1:0] tagsInFrame,
  input wire logic [2:0] lookupTagAPcpValue,
  input wire logic [2:0] lookupTagBPcpValue,
  input wire logic lookupTagADeiValue,
  input wire logic lookupTagBDeiValue,
  input wire logic [11:0] lookupTagAVidValue,
  input wire logic [11:0] lookupTagBVidValue,
  input wire logic [5:0] classDscp,
  input wire logic [15:0] etherType,
  input wire logic [7:0] ipVerIhl,
  input wire logic [7:0] ipTos,
  input wire logic [7:0] ipNextProto,
  input wire logic [15:0] ipChecksum,
  input wire logic cpuInjected,
  input wire logic [2:0] rewriteOpCode,
  input wire logic addSubMode,
  input wire logic egressDelayReq,
  input wire logic ingressBackplane,
  input wire logic [47:0] rxStamp,
  input wire logic [47:0] txStamp,
  input wire logic [47:0] todSeconds,
  input wire logic [63:0] oldCorrection,
  // Edit commands to port datapath
  output logic outValid,
  output logic [1:0] tagPushCount,
  output logic [31:0] outerTag,
  output logic [31:0] innerTag,
  output logic dscpWrite,
  output logic [7:0] newTos,
  output logic checksumWrite,
  output logic [15:0] newChecksum,
  output logic fcsUpdate,
  output logic ptpFound,
  output logic [10:0] ptpHeaderOffset,
  output logic corrWrite,
  output logic [63:0] newCorrection,
  output logic resvWrite,
  output logic [31:0] resvValue,
  output logic todWrite,
  output logic [79:0] todValue
);
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [6:0] tagCfg_r [3];
  logic [31:0] portVlan_r;
  logic [6:0] egressCfg_r;
  logic [31:0] egressDelay_r;
  logic [3:0] prioMap_r [16];
  logic [5:0] dscpGreen_r [64];
  logic [5:0] dscpYellow_r [64];
  logic [15:0] frameCount_r;
  logic [15:0] ptpEditCount_r;
  logic [31:0] rdData;
  logic rdErr;
  logic wrEn;
  logic [3:0] mapEntry;
  logic [31:0] portTag, tagA, tagB;
  logic [1:0] pushCnt_nxt;
  logic [31:0] outer_nxt, inner_nxt;
  logic [2:0] tagsTotal;
  logic [10:0] l2Len;
  logic found_nxt;
  logic [10:0] ofs_nxt;
  logic oneStep, egrBp;
  logic [47:0] delay48, delta48;
  logic corrW_nxt, resvW_nxt, todW_nxt, ptpEdit;
  logic [31:0] resv_nxt;
  logic [5:0] dscp_nxt;
  logic dscpW_nxt, csumW_nxt, fcs_nxt;
  logic [15:0] csum_nxt;
  logic outValid_r, dscpWrite_r, checksumWrite_r, fcsUpdate_r, ptpFound_r;
  logic corrWrite_r, resvWrite_r, todWrite_r;
  logic [1:0] tagPushCount_r;
  logic [31:0] outerTag_r, innerTag_r, resvValue_r;
  logic [7:0] newTos_r;
  logic [15:0] newChecksum_r;
  logic [10:0] ptpHeaderOffset_r;
  logic [63:0] newCorrection_r;
  logic [79:0] todValue_r;

  function automatic logic [15:0] onesAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // Tag word {tpid, pcp, dei, vid}; cfgX are port defaults or action values
  function automatic logic [31:0] buildTag(input logic [6:0] cfg, input logic isLookup,
    input logic [2:0] cfgPcp, input logic cfgDei, input logic [11:0] cfgVid);
    logic [2:0] pcp;
    logic dei;
    logic [11:0] vid;
    logic [15:0] tpid;
    case (field_sel_t'(cfg[CFG_PCP_LSB +: 2]))
      SEL_CLASSIFIED: pcp = classPcp;
      SEL_CONFIGURED: pcp = cfgPcp;
      SEL_MAPPED: pcp = mapEntry[3:1];
      default: pcp = qosClass;
    endcase
    case (field_sel_t'(cfg[CFG_DEI_LSB +: 2]))
      SEL_CLASSIFIED: dei = classDei;
      SEL_CONFIGURED: dei = cfgDei;
      SEL_MAPPED: dei = mapEntry[0];
      default: dei = dropLevel;
    endcase
    if (cfg[CFG_VID_BIT])
      vid = cfgVid;
    else if (isLookup)
      vid = classVid + cfgVid;
    else
      vid = classVid;
    case (tpid_sel_t'(cfg[CFG_TPID_LSB +: 2]))
      TPID_C: tpid = TPID_CTAG;
      TPID_S: tpid = TPID_STAG;
      TPID_CUSTOM: tpid = portVlan_r[PV_TPID_LSB +: 16];
      default: tpid = classCtag ? TPID_CTAG : portVlan_r[PV_TPID_LSB +: 16];
    endcase
    return {tpid, pcp, dei, vid};
  endfunction

  assign wrEn = psel & penable & pready_r & pwrite;

  // One wait state: the answer comes in the second access cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & rdErr;
      prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rdData : 32'h0000_0000;
    end
  end

  always_comb
  begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    if (paddr == ADDR_TAG_PORT)
      rdData = {25'h0000000, tagCfg_r[0]};
    else if (paddr == ADDR_TAG_A)
      rdData = {25'h0000000, tagCfg_r[1]};
    else if (paddr == ADDR_TAG_B)
      rdData = {25'h0000000, tagCfg_r[2]};
    else if (paddr == ADDR_PORT_VLAN)
      rdData = portVlan_r;
    else if (paddr == ADDR_EGRESS_CFG)
      rdData = {25'h0000000, egressCfg_r};
    else if (paddr == ADDR_DELAY)
      rdData = egressDelay_r;
    else if (paddr == ADDR_STATUS)
      rdData = {ptpEditCount_r, frameCount_r};
    else if (paddr[11:6] == PRIO_MAP_PAGE)
      rdData = {28'h0000000, prioMap_r[paddr[5:2]]};
    else if (paddr[11:8] == DSCP_GREEN_PAGE)
      rdData = {26'h0000000, dscpGreen_r[paddr[7:2]]};
    else if (paddr[11:8] == DSCP_YELLOW_PAGE)
      rdData = {26'h0000000, dscpYellow_r[paddr[7:2]]};
    else
      rdErr = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
        tagCfg_r[i] <= TAG_CFG_RST;
      portVlan_r <= PORT_VLAN_RST;
      egressCfg_r <= EGRESS_CFG_RST;
      egressDelay_r <= DELAY_RST;
    end
    else if (wrEn)
    begin
      if (paddr == ADDR_TAG_PORT)
        tagCfg_r[0] <= pwdata[6:0];
      else if (paddr == ADDR_TAG_A)
        tagCfg_r[1] <= pwdata[6:0];
      else if (paddr == ADDR_TAG_B)
        tagCfg_r[2] <= pwdata[6:0];
      else if (paddr == ADDR_PORT_VLAN)
        portVlan_r <= pwdata;
      else if (paddr == ADDR_EGRESS_CFG)
        egressCfg_r <= pwdata[6:0];
      else if (paddr == ADDR_DELAY)
        egressDelay_r <= pwdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        prioMap_r[i] <= 4'h0;
      for (int i = 0; i < 64; i++)
      begin
        dscpGreen_r[i] <= 6'h00;
        dscpYellow_r[i] <= 6'h00;
      end
    end
    else if (wrEn)
    begin
      if (paddr[11:6] == PRIO_MAP_PAGE)
        prioMap_r[paddr[5:2]] <= pwdata[3:0];
      else if (paddr[11:8] == DSCP_GREEN_PAGE)
        dscpGreen_r[paddr[7:2]] <= pwdata[5:0];
      else if (paddr[11:8] == DSCP_YELLOW_PAGE)
        dscpYellow_r[paddr[7:2]] <= pwdata[5:0];
    end
  end

  // Tag building and insertion
  always_comb
  begin
    mapEntry = prioMap_r[{qosClass, dropLevel}];
    portTag = buildTag(tagCfg_r[0], 1'b0, portVlan_r[PV_PCP_LSB +: 3],
      portVlan_r[PV_DEI_BIT], portVlan_r[PV_VID_LSB +: 12]);
    tagA = buildTag(tagCfg_r[1], 1'b1, lookupTagAPcpValue, lookupTagADeiValue,
      lookupTagAVidValue);
    tagB = buildTag(tagCfg_r[2], 1'b1, lookupTagBPcpValue, lookupTagBDeiValue,
      lookupTagBVidValue);
    outer_nxt = 32'h0000_0000;
    inner_nxt = 32'h0000_0000;
    pushCnt_nxt = 2'h0;
    if (tagPushMask[1] || tagPushMask[0])
    begin
      outer_nxt = tagPushMask[1] ? tagA : portTag;
      inner_nxt = tagPushMask[2] ? tagB : 32'h0000_0000;
      pushCnt_nxt = tagPushMask[2] ? 2'h2 : 2'h1;
    end
    else if (tagPushMask[2])
    begin
      outer_nxt = tagB;
      pushCnt_nxt = 2'h1;
    end
  end

  // PTP header position in the outgoing frame
  always_comb
  begin
    tagsTotal = {1'b0, tagsInFrame} + {1'b0, pushCnt_nxt};
    l2Len = ETH_HDR_LEN + {6'h00, tagsTotal, 2'h0};
    found_nxt = 1'b0;
    ofs_nxt = 11'h000;
    if (etherType == ETYPE_PTP)
    begin
      found_nxt = 1'b1;
      ofs_nxt = l2Len;
    end
    else if (etherType == ETYPE_IPV4 && ipNextProto == IP_PROTO_UDP)
    begin
      found_nxt = 1'b1;
      ofs_nxt = l2Len + {5'h00, ipVerIhl[3:0], 2'h0} + UDP_HDR_LEN;
    end
    else if (etherType == ETYPE_IPV6 && ipNextProto == IP_PROTO_UDP)
    begin
      found_nxt = 1'b1;
      ofs_nxt = l2Len + IPV6_HDR_LEN + UDP_HDR_LEN;
    end
  end

  // Timestamp actions
  always_comb
  begin
    egrBp = egressCfg_r[EC_BACKPLANE_BIT];
    oneStep = rewriteOpCode == OP_ONE_STEP && !egressCfg_r[EC_ONESTEP_DIS_BIT] && found_nxt;
    delay48 = egressDelayReq ? {16'h0000, egressDelay_r} : 48'h0;
    delta48 = 48'h0;
    corrW_nxt = 1'b0;
    resvW_nxt = 1'b0;
    resv_nxt = 32'h0000_0000;
    if (oneStep && !ingressBackplane && !egrBp)
    begin
      corrW_nxt = 1'b1;
      delta48 = txStamp - rxStamp + delay48;
    end
    else if (oneStep && !ingressBackplane && egrBp)
    begin
      if (addSubMode)
      begin
        corrW_nxt = 1'b1;
        delta48 = 48'h0 - rxStamp;
      end
      else
      begin
        resvW_nxt = 1'b1;
        resv_nxt = rxStamp[31:0];
      end
    end
    else if (oneStep && ingressBackplane && !egrBp)
    begin
      corrW_nxt = 1'b1;
      resvW_nxt = 1'b1;
      if (addSubMode)
        delta48 = txStamp + delay48;
      else
        delta48 = txStamp - rxStamp + delay48;
    end
    todW_nxt = rewriteOpCode == OP_ORIGIN && !egressCfg_r[EC_ONESTEP_DIS_BIT] && found_nxt
      && !egrBp;
    ptpEdit = corrW_nxt | resvW_nxt | todW_nxt;
  end

  // DSCP, checksum and FCS
  always_comb
  begin
    case (dscp_mode_t'(egressCfg_r[EC_DSCP_LSB +: 2]))
      DSCP_CLASSIFIED: dscp_nxt = classDscp;
      DSCP_MAP: dscp_nxt = dscpGreen_r[classDscp];
      DSCP_MAP_BY_DROP: dscp_nxt = dropLevel ? dscpYellow_r[classDscp] : dscpGreen_r[classDscp];
      default: dscp_nxt = ipTos[7:2];
    endcase
    dscpW_nxt = (etherType == ETYPE_IPV4 || etherType == ETYPE_IPV6) && !ptpEdit
      && egressCfg_r[EC_DSCP_LSB +: 2] != DSCP_KEEP;
    csumW_nxt = dscpW_nxt && etherType == ETYPE_IPV4;
    csum_nxt = ~onesAdd(onesAdd(~ipChecksum, ~{ipVerIhl, ipTos}),
      {ipVerIhl, dscp_nxt, ipTos[1:0]});
    if (cpuInjected)
      fcs_nxt = egressCfg_r[EC_CPU_FCS_BIT];
    else
      case (fcs_mode_t'(egressCfg_r[EC_FCS_LSB +: 2]))
        FCS_IF_EDITED: fcs_nxt = ptpEdit | dscpW_nxt | tagsPopped | (pushCnt_nxt != 2'h0);
        FCS_ALWAYS: fcs_nxt = 1'b1;
        default: fcs_nxt = 1'b0;
      endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      outValid_r <= 1'b0;
    else
      outValid_r <= inValid;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {dscpWrite_r, checksumWrite_r, fcsUpdate_r, ptpFound_r} <= 4'h0;
      {corrWrite_r, resvWrite_r, todWrite_r} <= 3'h0;
      tagPushCount_r <= 2'h0;
      outerTag_r <= 32'h0000_0000;
      innerTag_r <= 32'h0000_0000;
      newTos_r <= 8'h00;
      newChecksum_r <= 16'h0000;
      ptpHeaderOffset_r <= 11'h000;
      newCorrection_r <= 64'h0;
      resvValue_r <= 32'h0000_0000;
      todValue_r <= 80'h0;
    end
    else if (inValid)
    begin
      tagPushCount_r <= pushCnt_nxt;
      outerTag_r <= outer_nxt;
      innerTag_r <= inner_nxt;
      dscpWrite_r <= dscpW_nxt;
      newTos_r <= {dscp_nxt, ipTos[1:0]};
      checksumWrite_r <= csumW_nxt;
      newChecksum_r <= csum_nxt;
      fcsUpdate_r <= fcs_nxt;
      ptpFound_r <= found_nxt;
      ptpHeaderOffset_r <= ofs_nxt;
      corrWrite_r <= corrW_nxt;
      newCorrection_r <= oldCorrection + {delta48, 16'h0000};
      resvWrite_r <= resvW_nxt;
      resvValue_r <= resv_nxt;
      todWrite_r <= todW_nxt;
      todValue_r <= {todSeconds, txStamp[31:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameCount_r <= 16'h0000;
      ptpEditCount_r <= 16'h0000;
    end
    else if (inValid)
    begin
      frameCount_r <= frameCount_r + 16'h0001;
      if (ptpEdit)
        ptpEditCount_r <= ptpEditCount_r + 16'h0001;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign outValid = outValid_r;
  assign tagPushCount = tagPushCount_r;
  assign outerTag = outerTag_r;
  assign innerTag = innerTag_r;
  assign dscpWrite = dscpWrite_r;
  assign newTos = newTos_r;
  assign checksumWrite = checksumWrite_r;
  assign newChecksum = newChecksum_r;
  assign fcsUpdate = fcsUpdate_r;
  assign ptpFound = ptpFound_r;
  assign ptpHeaderOffset = ptpHeaderOffset_r;
  assign corrWrite = corrWrite_r;
  assign newCorrection = newCorrection_r;
  assign resvWrite = resvWrite_r;
  assign resvValue = resvValue_r;
  assign todWrite = todWrite_r;
  assign todValue = todValue_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stamp_in;
    inValid && rewriteOpCode == OP_ONE_STEP && found_nxt && !egressCfg_r[EC_ONESTEP_DIS_BIT];
  endsequence
  sequence s_egress_bp;
    s_stamp_in ##0 (!ingressBackplane && egrBp);
  endsequence
  sequence s_ingress_bp;
    s_stamp_in ##0 (ingressBackplane && !egrBp);
  endsequence

  property p_tpid_ctag;
    inValid && tagPushMask == 3'b001 && tagCfg_r[0][CFG_TPID_LSB +: 2] == TPID_C
      |=> outerTag[31:16] == TPID_CTAG;
  endproperty
  a_tpid_ctag: assert property (p_tpid_ctag) else $error("port tag tpid wrong");
  property p_lookup_vid;
    inValid && tagPushMask[1] && !tagCfg_r[1][CFG_VID_BIT]
      |=> outerTag[11:0] == $past(classVid + lookupTagAVidValue);
  endproperty
  a_lookup_vid: assert property (p_lookup_vid) else $error("lookup vid wrong");
  property p_dscp_keep;
    inValid && egressCfg_r[1:0] == DSCP_KEEP |=> !dscpWrite && !checksumWrite;
  endproperty
  a_dscp_keep: assert property (p_dscp_keep) else $error("dscp written in keep");
  property p_csum_ipv4;
    outValid && checksumWrite |-> dscpWrite && $past(etherType) == ETYPE_IPV4;
  endproperty
  a_csum_ipv4: assert property (p_csum_ipv4) else $error("checksum without ipv4");
  property p_no_dscp_ptp;
    outValid && (corrWrite || resvWrite || todWrite) |-> !dscpWrite;
  endproperty
  a_no_dscp_ptp: assert property (p_no_dscp_ptp) else $error("dscp on ptp frame");
  property p_fcs_never;
    inValid && !cpuInjected && egressCfg_r[3:2] == FCS_NEVER |=> !fcsUpdate;
  endproperty
  a_fcs_never: assert property (p_fcs_never) else $error("fcs update when never");
  property p_fcs_cpu;
    inValid && cpuInjected |=> fcsUpdate == $past(egressCfg_r[EC_CPU_FCS_BIT]);
  endproperty
  a_fcs_cpu: assert property (p_fcs_cpu) else $error("cpu fcs mismatch");
  property p_set_resv;
    s_egress_bp ##0 !addSubMode |=> resvWrite && !corrWrite && resvValue == $past(rxStamp[31:0]);
  endproperty
  a_set_resv: assert property (p_set_resv) else $error("reserved not set to rx");
  property p_clear_resv;
    s_ingress_bp |=> resvWrite && corrWrite && resvValue == 32'h0000_0000;
  endproperty
  a_clear_resv: assert property (p_clear_resv) else $error("reserved not cleared");
  property p_both_bp;
    s_stamp_in ##0 (ingressBackplane && egrBp) |=> !corrWrite && !resvWrite && !todWrite;
  endproperty
  a_both_bp: assert property (p_both_bp) else $error("edit with both backplanes");
endmodule
`default_nettype wire

// *** egress_rewriter_pkg.sv ***
package egress_rewriter_pkg;
  localparam logic [11:0] ADDR_TAG_PORT = 12'h000;
  localparam logic [11:0] ADDR_TAG_A = 12'h004;
  localparam logic [11:0] ADDR_TAG_B = 12'h008;
  localparam logic [11:0] ADDR_PORT_VLAN = 12'h00C;
  localparam logic [11:0] ADDR_EGRESS_CFG = 12'h010;
  localparam logic [11:0] ADDR_DELAY = 12'h014;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [5:0] PRIO_MAP_PAGE = 6'h01;
  localparam logic [3:0] DSCP_GREEN_PAGE = 4'h1;
  localparam logic [3:0] DSCP_YELLOW_PAGE = 4'h2;
  localparam int CFG_PCP_LSB = 0;
  localparam int CFG_DEI_LSB = 2;
  localparam int CFG_VID_BIT = 4;
  localparam int CFG_TPID_LSB = 5;
  localparam int PV_VID_LSB = 0;
  localparam int PV_DEI_BIT = 12;
  localparam int PV_PCP_LSB = 13;
  localparam int PV_TPID_LSB = 16;
  localparam int EC_DSCP_LSB = 0;
  localparam int EC_FCS_LSB = 2;
  localparam int EC_CPU_FCS_BIT = 4;
  localparam int EC_BACKPLANE_BIT = 5;
  localparam int EC_ONESTEP_DIS_BIT = 6;
  localparam logic [6:0] TAG_CFG_RST = 7'h00;
  localparam logic [31:0] PORT_VLAN_RST = 32'h8100_0001;
  localparam logic [6:0] EGRESS_CFG_RST = 7'h04;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88A8;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [15:0] ETYPE_IPV6 = 16'h86DD;
  localparam logic [15:0] ETYPE_PTP = 16'h88F7;
  localparam logic [7:0] IP_PROTO_UDP = 8'h11;
  localparam logic [10:0] ETH_HDR_LEN = 11'h00E;
  localparam logic [10:0] IPV6_HDR_LEN = 11'h028;
  localparam logic [10:0] UDP_HDR_LEN = 11'h008;
  localparam logic [10:0] PTP_CORR_OFS = 11'h008;
  localparam logic [10:0] PTP_RESV_OFS = 11'h010;
  localparam logic [10:0] PTP_TOD_OFS = 11'h022;
  typedef enum logic [1:0] {SEL_CLASSIFIED = 2'b00, SEL_CONFIGURED = 2'b01,
    SEL_MAPPED = 2'b10, SEL_DIRECT = 2'b11} field_sel_t;
  typedef enum logic [1:0] {TPID_C = 2'b00, TPID_S = 2'b01, TPID_CUSTOM = 2'b10,
    TPID_CUSTOM_C = 2'b11} tpid_sel_t;
  typedef enum logic [1:0] {DSCP_KEEP = 2'b00, DSCP_CLASSIFIED = 2'b01,
    DSCP_MAP = 2'b10, DSCP_MAP_BY_DROP = 2'b11} dscp_mode_t;
  typedef enum logic [1:0] {FCS_NEVER = 2'b00, FCS_IF_EDITED = 2'b01,
    FCS_ALWAYS = 2'b10} fcs_mode_t;
  typedef enum logic [2:0] {OP_NONE = 3'b000, OP_ONE_STEP = 3'b001,
    OP_TWO_STEP = 3'b010, OP_ORIGIN = 3'b011} rewrite_op_t;
endpackage

// *** tb_egress_frame_rewriter.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_egress_frame_rewriter;
  import egress_rewriter_pkg::*;
  localparam logic [6:0] EB = 7'h4C;
  localparam logic [6:0] IB = 7'h70;
  localparam logic [6:0] AS = 7'h1A;
  localparam logic [6:0] DL = 7'h11;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, outerTag, innerTag, resvValue, q;
  logic pready, pslverr, outValid, dscpWrite, checksumWrite, fcsUpdate, ptpFound, corrWrite;
  logic resvWrite, todWrite, inValid, addSubMode, egressDelayReq, ingressBackplane;
  logic err, e, i, a, d, cw, rw;
  logic [1:0] tagPushCount, tagsInFrame = 2'h0;
  logic [7:0] newTos, ipVerIhl = 8'h45, ipTos = 8'h02, ipNextProto = 8'h06;
  logic [15:0] newChecksum, etherType = 16'h0800, ipChecksum = 16'h1234;
  logic [10:0] ptpHeaderOffset;
  logic [63:0] newCorrection, delta, oldCorrection = 64'h1_0000_0000;
  logic [79:0] todValue;
  logic [2:0] rewriteOpCode, classPcp = 3'h7, qosClass = 3'h6, tagPushMask = 3'h0;
  logic [2:0] lookupTagAPcpValue = 3'h3, lookupTagBPcpValue = 3'h1;
  logic [47:0] rxStamp, txStamp, todSeconds = 48'h1234_5678;
  logic classDei = 1'h0, classCtag = 1'h1, dropLevel = 1'h1, tagsPopped = 1'h0;
  logic cpuInjected = 1'h0, lookupTagADeiValue = 1'h1, lookupTagBDeiValue = 1'h1;
  logic [11:0] classVid = 12'h055, lookupTagAVidValue = 12'h010, lookupTagBVidValue = 12'h0AB;
  logic [5:0] classDscp = 6'h2E;
  logic [5:0] dscpExp [4] = '{6'h2E, 6'h2E, 6'h11, 6'h0A};
  logic [7:0] fcsCfg [4] = '{8'h01, 8'h08, 8'h08, 8'h10};
  int miscompares = 0;
  int numChecks = 0;
  int k;

  always #20 core_clk = ~core_clk;

  analyzer_model i_ana (.core_clk, .inValid, .rewriteOpCode, .addSubMode, .egressDelayReq,
    .ingressBackplane, .rxStamp, .txStamp);
  egress_frame_rewriter i_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .inValid, .classPcp, .classDei, .classVid, .classCtag, .qosClass,
    .dropLevel, .tagPushMask, .tagsPopped, .tagsInFrame, .lookupTagAPcpValue,
    .lookupTagBPcpValue, .lookupTagADeiValue, .lookupTagBDeiValue, .lookupTagAVidValue,
    .lookupTagBVidValue, .classDscp, .etherType, .ipVerIhl, .ipTos, .ipNextProto, .ipChecksum,
    .cpuInjected, .rewriteOpCode, .addSubMode, .egressDelayReq, .ingressBackplane, .rxStamp,
    .txStamp, .todSeconds, .oldCorrection, .outValid, .tagPushCount, .outerTag, .innerTag,
    .dscpWrite, .newTos, .checksumWrite, .newChecksum, .fcsUpdate, .ptpFound, .ptpHeaderOffset,
    .corrWrite, .newCorrection, .resvWrite, .resvValue, .todWrite, .todValue);

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'h1, ad, wd, rd, er);
  endtask

  task automatic frame(input logic [2:0] op, input logic as, input logic dl, input logic ib);
    i_ana.send(op, as, dl, ib, 48'h3E8, 48'h5DC);
    @(posedge core_clk);
    chk(outValid, 1'h1);
  endtask

  // Incremental ones-complement update for one changed header word
  function automatic logic [15:0] ipSum(input logic [15:0] hc, input logic [15:0] mo,
    input logic [15:0] mn);
    logic [17:0] s;
    s = {2'h0, ~hc} + {2'h0, ~mo} + {2'h0, mn};
    s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
    s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
    return ~s[15:0];
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    miscompares++;
    close_out;
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    apb(1'h0, ADDR_PORT_VLAN, 32'h0, q, err);
    chk(q, PORT_VLAN_RST);
    apb(1'h0, 12'hFFC, 32'h0, q, err);
    chk({err, q}, 33'h1_0000_0000);
    wr(ADDR_PORT_VLAN, 32'h9100_B123);
    wr(ADDR_TAG_PORT, 32'h3F);
    wr(ADDR_TAG_A, 32'h61);
    wr(ADDR_TAG_B, 32'h5A);
    wr(12'h074, 32'h4);
    tagPushMask <= 3'h1;
    frame(3'h0, 1'h0, 1'h0, 1'h0);
    chk({tagPushCount, outerTag, innerTag}, {2'h1, 32'h88A8_D123, 32'h0});
    tagPushMask <= 3'h6;
    frame(3'h0, 1'h0, 1'h0, 1'h0);
    chk({tagPushCount, outerTag, innerTag}, {2'h2, 32'h8100_6065, 32'h9100_40AB});
    classCtag <= 1'h0;
    frame(3'h0, 1'h0, 1'h0, 1'h0);
    chk(outerTag, 32'h9100_6065);
    wr(ADDR_TAG_PORT, 32'h14);
    tagPushMask <= 3'h1;
    frame(3'h0, 1'h0, 1'h0, 1'h0);
    chk({fcsUpdate, outerTag}, {1'h1, 32'h8100_F123});
    tagPushMask <= 3'h0;
    wr(12'h1B8, 32'h11);
    wr(12'h2B8, 32'h0A);
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_EGRESS_CFG, 32'h4 | k);
      frame(3'h0, 1'h0, 1'h0, 1'h0);
      chk({dscpWrite, fcsUpdate}, {2{k != 0}});
      if (k != 0)
        chk({newTos, checksumWrite, newChecksum}, {dscpExp[k], 3'h5,
          ipSum(16'h1234, 16'h4502, {8'h45, dscpExp[k], 2'h2})});
    end
    etherType <= ETYPE_IPV6;
    frame(3'h0, 1'h0, 1'h0, 1'h0);
    chk({dscpWrite, checksumWrite}, 2'h2);
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_EGRESS_CFG, {24'h0, fcsCfg[k]});
      cpuInjected <= k[1];
      frame(3'h0, 1'h0, 1'h0, 1'h0);
      chk(fcsUpdate, 4'hA >> k & 1);
    end
    cpuInjected <= 1'h0;
    etherType <= ETYPE_IPV4;
    ipNextProto <= IP_PROTO_UDP;
    wr(ADDR_DELAY, 32'h7);
    for (k = 0; k < 7; k++)
    begin
      {e, i, a, d} = {EB[k], IB[k], AS[k], DL[k]};
      wr(ADDR_EGRESS_CFG, {26'h0, e, 5'h01});
      frame(3'h1, a, d, i);
      cw = !e | (a & !i);
      rw = (i & !e) | (e & !i & !a);
      delta = e ? -64'h3E8 : ((a & i) ? 64'h5DC : 64'h1F4) + (d ? 64'h7 : 64'h0);
      chk({corrWrite, resvWrite, dscpWrite}, {cw, rw, !(cw | rw)});
      if (cw)
        chk(newCorrection, oldCorrection + (delta << 16));
      if (rw)
        chk(resvValue, e ? 32'h3E8 : 32'h0);
    end
    wr(ADDR_EGRESS_CFG, 32'h01);
    tagsInFrame <= 2'h1;
    for (k = 0; k < 2; k++)
    begin
      etherType <= k ? ETYPE_PTP : ETYPE_IPV6;
      frame(3'h1, 1'h0, 1'h0, 1'h0);
      chk({ptpFound, corrWrite, ptpHeaderOffset}, {2'h3, k ? 11'h012 : 11'h042});
    end
    frame(3'h3, 1'h0, 1'h0, 1'h0);
    chk(todWrite, 1'h1);
    chk(todValue, {48'h1234_5678, 32'h5DC});
    apb(1'h0, ADDR_STATUS, 32'h0, q, err);
    chk({err, q}, 33'h0_0009_0017);
    close_out;
  end
endmodule
`default_nettype wire
